/* logic/scmc_pkg.sv */
// Purpose: Shared constants and types of the system clock and mode control.
// Assumes: One 100 MHz reference clock models both RC oscillators.
// Notes: Oscillator half periods are derived from the reference rate.
`default_nettype none

package scmc_pkg;

  // ----------------------------------------------------------------------
  // Rates
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 32'h05F5_E100;
  localparam int FAST_OSC_HZ = 32'h007A_1200;
  localparam int SLOW_OSC_HZ = 32'h0000_7D00;
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_OSC_HZ);
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_OSC_HZ);

  // ----------------------------------------------------------------------
  // Divider and source selection
  // ----------------------------------------------------------------------
  localparam int DIV_W = 32'h0000_0006;
  localparam int SEL_W = 32'h0000_0003;
  localparam int NUM_SRC = 32'h0000_0008;
  localparam logic [2:0] SEL_SLOW = 3'h0;
  localparam logic [2:0] SEL_FAST = 3'h7;
  localparam logic [2:0] DIVSEL_FIRST_FAST = 3'h2;
  localparam logic [2:0] DIVSEL_TO_SEL = 3'h1;

  // ----------------------------------------------------------------------
  // Gated clock slots
  // ----------------------------------------------------------------------
  localparam int NUM_GATES = 32'h0000_0004;
  localparam int GATE_CPU = 32'h0000_0000;
  localparam int GATE_SYS = 32'h0000_0001;
  localparam int GATE_SLOW = 32'h0000_0002;
  localparam int GATE_TBC = 32'h0000_0003;

  typedef enum logic [2:0] {
    MODE_FULL_SPEED,
    MODE_LOW_SPEED,
    MODE_IDLE_STOPPED,
    MODE_IDLE_RUNNING,
    MODE_DEEP_SLEEP,
    MODE_SLEEP_WDT
  } scmc_mode_e;

endpackage : scmc_pkg

`default_nettype wire

/* logic/scmc_gate_if.sv */
// Purpose: Carries clock sources, run enables and gated clocks as one group.
// Assumes: All members are levels in the reference clock domain.
// Notes: One bit per gated clock slot.
`timescale 1ns/1ns
`default_nettype none

interface scmc_gate_if #(parameter int N = 4);
  logic [N-1:0] src;
  logic [N-1:0] en;
  logic [N-1:0] out;
  modport ctl (output src, output en, input out);
  modport gate (input src, input en, output out);
endinterface : scmc_gate_if

`default_nettype wire

/* logic/scmc_rc_osc.sv */
// Purpose: Behavioural RC oscillator producing a square level when enabled.
// Assumes: HALF is the number of reference cycles per half period.
// Notes: A high phase in progress is finished before the oscillator stops, so no runt leaves it.
`timescale 1ns/1ns
`default_nettype none

module scmc_rc_osc #(
  parameter int HALF = 6
) (
  input wire logic clk,      // reference clock
  input wire logic rst,      // synchronous reset
  input wire logic enable,   // oscillator runs while high
  output logic level         // oscillator output level
);
  localparam int CW = $clog2(HALF) + 1;
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_reg;
  logic lvl_reg;
  wire wrap = (cnt_reg == LAST);

  always_ff @(posedge clk) begin
    if (rst || (!enable && !lvl_reg)) begin
      cnt_reg <= '0;
      lvl_reg <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      lvl_reg <= wrap ? ~lvl_reg : lvl_reg;
    end
  end

  assign level = lvl_reg;
endmodule : scmc_rc_osc

`default_nettype wire

/* logic/scmc_clk_gate.sv */
// Purpose: Glitch-free gating of several clock levels.
// Assumes: Sources are levels sampled in the reference clock domain.
// Notes: An enable takes effect only while its source is low.
`timescale 1ns/1ns
`default_nettype none

module scmc_clk_gate #(
  parameter int N = 4
) (
  input wire logic clk,          // reference clock
  input wire logic rst,          // synchronous reset
  scmc_gate_if.gate g            // sources, enables, gated outputs
);
  logic [N-1:0] en_eff_reg;
  logic [N-1:0] out_reg;

  // ----------------------------------------------------------------------
  // Per-slot gate
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_slot
    always_ff @(posedge clk) begin
      if (rst) begin
        en_eff_reg[i] <= 1'b0;
        out_reg[i] <= 1'b0;
      end else begin
        if (!g.src[i]) begin
          en_eff_reg[i] <= g.en[i]; // RULE18
        end
        out_reg[i] <= g.src[i] & en_eff_reg[i];
      end
    end

    property p_gated_low;
      @(posedge clk) disable iff (rst)
      (!en_eff_reg[i] && !out_reg[i]) |=> !out_reg[i];
    endproperty
    a_gated_low: assert property (p_gated_low) // RULE18
      else $error("Gated clock moved while its slot was off.");
  end

  assign g.out = out_reg;
endmodule : scmc_clk_gate

`default_nettype wire

/* logic/scmc_top.sv */
// Purpose: Selects the system clock and gates clocks by operating mode.
// Assumes: Control bits are synchronous levels; halt and wake are pulses.
// Notes: Oscillators are modelled from the reference clock.
// Operation
// [RULE1] A fast RC oscillator near 8 MHz is provided.
// [RULE2] A slow RC oscillator near 32 kHz is provided.
// [RULE3] Speed bit and divider field choose fast or slow system clock.
// [RULE4] Fast source gives undivided or divided clock down to one sixty-fourth.
// [RULE5] The source may change at run time without a reset.
// [RULE6] The time-base clock comes from the slow oscillator for time base and timers.
// [RULE7] The slow oscillator also clocks the watchdog.
// [RULE8] Full speed: CPU runs on fast clock or division; slow and time-base run.
// [RULE9] Low speed: CPU runs on slow clock; slow and time-base clocks run.
// [RULE10] Stopped idle: CPU and system clocks off; slow and time-base run.
// [RULE11] Running idle: CPU off; system, slow and time-base clocks run.
// [RULE12] Deep sleep: every clock stopped.
// [RULE13] Watchdog sleep: CPU, system and time-base off; slow clock runs.
// [RULE14] Halt with idle select low sleeps; high enters idle.
// [RULE15] In idle, the keep bit chooses stopped or running system clock.
// [RULE16] In watchdog sleep the slow clock runs only while watchdog enabled.
// [RULE17] Source or ratio switches never glitch the system clock.
// [RULE18] A gated-off clock holds a stable level until re-enabled.
`timescale 1ns/1ns
`default_nettype none

module scmc_top #(
  parameter int FAST_HALF = scmc_pkg::FAST_HALF_CYC,
  parameter int SLOW_HALF = scmc_pkg::SLOW_HALF_CYC
) (
  input wire logic clk,                         // reference clock, 100 MHz
  input wire logic rst,                         // synchronous reset, active high
  input wire logic clock_speed_select,          // 1 selects undivided fast clock
  input wire logic [2:0] clock_divider_select,  // divider or slow clock choice
  input wire logic idle_select,                 // halt enters idle when high
  input wire logic idle_clock_keep,             // idle keeps system clock when high
  input wire logic wdt_enable,                  // watchdog function enabled
  input wire logic halt_req,                    // halt instruction pulse
  input wire logic wake_req,                    // wake-up event pulse
  output logic cpu_clock,                       // gated CPU clock
  output logic system_clock,                    // gated system clock
  output logic slow_clock,                      // gated slow clock, watchdog clock
  output logic timebase_clock,                  // gated time-base clock
  output logic fast_rc_osc_on,                  // fast oscillator enabled
  output logic slow_rc_osc_on,                  // slow oscillator enabled
  output logic [2:0] op_mode,                   // current operating mode code
  output logic clock_switching                  // system clock switch in progress
);

  // ----------------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------------
  logic fast_en_reg;
  logic slow_en_reg;
  logic fast_lvl;
  logic slow_lvl;

  scmc_rc_osc #(.HALF(FAST_HALF)) u_fast_osc ( // RULE1
    .clk(clk),
    .rst(rst),
    .enable(fast_en_reg),
    .level(fast_lvl)
  );

  scmc_rc_osc #(.HALF(SLOW_HALF)) u_slow_osc ( // RULE2
    .clk(clk),
    .rst(rst),
    .enable(slow_en_reg),
    .level(slow_lvl)
  );

  // ----------------------------------------------------------------------
  // Fast clock divider
  // ----------------------------------------------------------------------
  logic [scmc_pkg::DIV_W-1:0] div_cnt_reg;
  logic fast_prev_reg;
  wire fast_rise = fast_lvl & ~fast_prev_reg;
  wire [scmc_pkg::DIV_W-1:0] div_cnt_next = fast_rise ? div_cnt_reg + 1'b1 : div_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_reg <= '0;
      fast_prev_reg <= 1'b0;
    end else begin
      div_cnt_reg <= div_cnt_next; // RULE4
      fast_prev_reg <= fast_lvl;
    end
  end

  // Source levels: slot 0 slow, 1..6 fast over 64 up to over 2, 7 undivided.
  logic [scmc_pkg::NUM_SRC-1:0] src_lvl;
  assign src_lvl[scmc_pkg::SEL_SLOW] = slow_lvl;
  assign src_lvl[scmc_pkg::SEL_FAST] = fast_lvl;
  for (genvar k = 1; k <= scmc_pkg::DIV_W; k++) begin : g_div_tap
    assign src_lvl[k] = div_cnt_reg[scmc_pkg::DIV_W-k]; // RULE4
  end

  // ----------------------------------------------------------------------
  // System clock source selection
  // ----------------------------------------------------------------------
  logic [scmc_pkg::SEL_W-1:0] sel_reg;
  logic hold_reg;
  logic sysraw_reg;

  wire divsel_slow = clock_divider_select < scmc_pkg::DIVSEL_FIRST_FAST;
  wire [scmc_pkg::SEL_W-1:0] divsel_idx = clock_divider_select - scmc_pkg::DIVSEL_TO_SEL;
  wire [scmc_pkg::SEL_W-1:0] sel_want = clock_speed_select ? scmc_pkg::SEL_FAST :
                                        divsel_slow ? scmc_pkg::SEL_SLOW : divsel_idx;
  wire cur_lvl = src_lvl[sel_reg];
  // Switch only while both the output and the old source are low.
  wire switch_ok = !sysraw_reg && !cur_lvl && (sel_want != sel_reg);
  wire [scmc_pkg::SEL_W-1:0] sel_next = switch_ok ? sel_want : sel_reg;
  wire hold_next = switch_ok | (hold_reg & cur_lvl);
  wire sysraw_next = (switch_ok | hold_reg) ? 1'b0 : cur_lvl;

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_reg <= scmc_pkg::SEL_FAST;
      hold_reg <= 1'b0;
      sysraw_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next; // RULE3 RULE5
      hold_reg <= hold_next; // RULE17
      sysraw_reg <= sysraw_next; // RULE17
    end
  end

  // ----------------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------------
  scmc_pkg::scmc_mode_e mode_reg;
  scmc_pkg::scmc_mode_e mode_next;
  scmc_pkg::scmc_mode_e run_mode;
  scmc_pkg::scmc_mode_e halt_mode;
  scmc_pkg::scmc_mode_e sleep_mode;
  scmc_pkg::scmc_mode_e idle_mode;

  wire running = (mode_reg == scmc_pkg::MODE_FULL_SPEED) ||
                 (mode_reg == scmc_pkg::MODE_LOW_SPEED);
  wire idling = (mode_reg == scmc_pkg::MODE_IDLE_STOPPED) ||
                (mode_reg == scmc_pkg::MODE_IDLE_RUNNING);
  wire sleeping = (mode_reg == scmc_pkg::MODE_DEEP_SLEEP) ||
                  (mode_reg == scmc_pkg::MODE_SLEEP_WDT);

  assign run_mode = (sel_reg == scmc_pkg::SEL_SLOW) ? scmc_pkg::MODE_LOW_SPEED :
                    scmc_pkg::MODE_FULL_SPEED; // RULE8 RULE9
  assign sleep_mode = wdt_enable ? scmc_pkg::MODE_SLEEP_WDT :
                      scmc_pkg::MODE_DEEP_SLEEP; // RULE16
  assign idle_mode = idle_clock_keep ? scmc_pkg::MODE_IDLE_RUNNING :
                     scmc_pkg::MODE_IDLE_STOPPED; // RULE15
  assign halt_mode = idle_select ? idle_mode : sleep_mode; // RULE14

  always_comb begin
    mode_next = mode_reg;
    unique case (mode_reg)
      scmc_pkg::MODE_FULL_SPEED,
      scmc_pkg::MODE_LOW_SPEED: begin
        mode_next = halt_req ? halt_mode : run_mode;
      end
      scmc_pkg::MODE_IDLE_STOPPED,
      scmc_pkg::MODE_IDLE_RUNNING: begin
        mode_next = wake_req ? run_mode : mode_reg;
      end
      scmc_pkg::MODE_DEEP_SLEEP,
      scmc_pkg::MODE_SLEEP_WDT: begin
        mode_next = wake_req ? run_mode : sleep_mode;
      end
      default: begin
        mode_next = run_mode;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Oscillator enables follow the next mode
  // ----------------------------------------------------------------------
  wire next_sys_on = (mode_next == scmc_pkg::MODE_FULL_SPEED) ||
                     (mode_next == scmc_pkg::MODE_LOW_SPEED) ||
                     (mode_next == scmc_pkg::MODE_IDLE_RUNNING);
  wire fast_needed = (sel_want != scmc_pkg::SEL_SLOW) || (sel_reg != scmc_pkg::SEL_SLOW);
  wire fast_en_next = next_sys_on && fast_needed;
  wire slow_en_next = (mode_next != scmc_pkg::MODE_DEEP_SLEEP); // RULE12 RULE16

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_reg <= scmc_pkg::MODE_FULL_SPEED;
      fast_en_reg <= 1'b0;
      slow_en_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      fast_en_reg <= fast_en_next;
      slow_en_reg <= slow_en_next;
    end
  end

  // ----------------------------------------------------------------------
  // Clock gating per mode
  // ----------------------------------------------------------------------
  scmc_gate_if #(.N(scmc_pkg::NUM_GATES)) gif ();

  assign gif.src[scmc_pkg::GATE_CPU] = sysraw_reg;
  assign gif.src[scmc_pkg::GATE_SYS] = sysraw_reg;
  assign gif.src[scmc_pkg::GATE_SLOW] = slow_lvl; // RULE7
  assign gif.src[scmc_pkg::GATE_TBC] = slow_lvl; // RULE6
  assign gif.en[scmc_pkg::GATE_CPU] = running; // RULE8 RULE9
  assign gif.en[scmc_pkg::GATE_SYS] = running ||
                                      (mode_reg == scmc_pkg::MODE_IDLE_RUNNING); // RULE11
  assign gif.en[scmc_pkg::GATE_SLOW] = running || idling ||
                                       (mode_reg == scmc_pkg::MODE_SLEEP_WDT); // RULE13
  assign gif.en[scmc_pkg::GATE_TBC] = running || idling; // RULE10 RULE12

  scmc_clk_gate #(.N(scmc_pkg::NUM_GATES)) u_gate (
    .clk(clk),
    .rst(rst),
    .g(gif.gate)
  );

  assign cpu_clock = gif.out[scmc_pkg::GATE_CPU];
  assign system_clock = gif.out[scmc_pkg::GATE_SYS];
  assign slow_clock = gif.out[scmc_pkg::GATE_SLOW];
  assign timebase_clock = gif.out[scmc_pkg::GATE_TBC];
  assign fast_rc_osc_on = fast_en_reg;
  assign slow_rc_osc_on = slow_en_reg;
  assign op_mode = mode_reg;
  assign clock_switching = hold_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_halt_run;
    running && halt_req;
  endsequence

  sequence s_full_high;
    sysraw_reg [*6];
  endsequence

  property p_halt_sleep;
    s_halt_run and !idle_select |=> sleeping;
  endproperty
  a_halt_sleep: assert property (p_halt_sleep) // RULE14
    else $error("Halt with idle select low did not sleep.");

  property p_halt_idle;
    s_halt_run and idle_select |=>
      (mode_reg == ($past(idle_clock_keep) ? scmc_pkg::MODE_IDLE_RUNNING :
                    scmc_pkg::MODE_IDLE_STOPPED));
  endproperty
  a_halt_idle: assert property (p_halt_idle) // RULE15
    else $error("Idle entry picked the wrong idle mode.");

  property p_deep_sleep;
    mode_reg == scmc_pkg::MODE_DEEP_SLEEP |->
      !slow_rc_osc_on && !fast_rc_osc_on && gif.en == '0;
  endproperty
  a_deep_sleep: assert property (p_deep_sleep) // RULE12
    else $error("A clock source stayed on in deep sleep.");

  property p_sleep_wdt;
    mode_reg == scmc_pkg::MODE_SLEEP_WDT |->
      slow_rc_osc_on && $past(wdt_enable) && !gif.en[scmc_pkg::GATE_TBC];
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) // RULE13 RULE16
    else $error("Watchdog sleep clocks wrong.");

  property p_idle_stopped;
    mode_reg == scmc_pkg::MODE_IDLE_STOPPED |->
      !gif.en[scmc_pkg::GATE_CPU] && !gif.en[scmc_pkg::GATE_SYS] &&
      gif.en[scmc_pkg::GATE_TBC] && slow_rc_osc_on;
  endproperty
  a_idle_stopped: assert property (p_idle_stopped) // RULE10
    else $error("Stopped idle clocks wrong.");

  property p_low_fast_off;
    (mode_next == scmc_pkg::MODE_LOW_SPEED && !fast_needed) |=> !fast_rc_osc_on;
  endproperty
  a_low_fast_off: assert property (p_low_fast_off) // RULE9
    else $error("Fast oscillator left on in low-speed mode.");

  property p_div_step;
    fast_rise |=> div_cnt_reg == $past(div_cnt_next);
  endproperty
  a_div_step: assert property (p_div_step) // RULE4
    else $error("Divider did not step on a fast clock edge.");

  property p_switch;
    switch_ok |=> (sel_reg == $past(sel_want)) && !sysraw_reg && hold_reg;
  endproperty
  a_switch: assert property (p_switch) // RULE3 RULE5
    else $error("Source switch did not take effect while low.");

  property p_no_runt;
    ($rose(sysraw_reg) && sel_reg == scmc_pkg::SEL_FAST) |-> s_full_high;
  endproperty
  a_no_runt: assert property (p_no_runt) // RULE17
    else $error("System clock high phase was cut short.");

endmodule : scmc_top

`default_nettype wire

/* testbench/scmc_clock_sink.sv */
// Purpose: Consumer model of the gated clocks, as seen by the core and the timers.
// Assumes: Clock levels are sampled on the reference clock.
// Notes: Counts rising edges and measures system clock period and high phases.
`timescale 1ns/1ns
`default_nettype none

module scmc_clock_sink (
  input wire logic clk,             // reference clock
  input wire logic clear,           // restarts the edge counts
  input wire logic cpu_clock,       // clock of the core
  input wire logic system_clock,    // clock of the peripherals
  input wire logic slow_clock,      // clock of the watchdog
  input wire logic timebase_clock,  // clock of the time base and timers
  output logic [31:0] cpu_edges,    // rising edges of the core clock
  output logic [31:0] sys_edges,    // rising edges of the system clock
  output logic [31:0] slow_edges,   // rising edges of the slow clock
  output logic [31:0] tbc_edges,    // rising edges of the time-base clock
  output logic [31:0] sys_period,   // cycles between the last two system edges
  output logic [31:0] sys_min_high  // shortest system clock high phase seen
);
  logic [3:0] last_reg = 4'h0;
  logic [31:0] since_reg = 32'h0000_0000;
  logic [31:0] high_reg = 32'h0000_0000;

  initial begin
    {cpu_edges, sys_edges, slow_edges, tbc_edges} = '0;
    sys_period = 32'h0000_0000;
    sys_min_high = 32'hFFFF_FFFF;
  end

  always @(posedge clk) begin
    last_reg <= {cpu_clock, system_clock, slow_clock, timebase_clock};
    since_reg <= since_reg + 1;
    high_reg <= system_clock ? high_reg + 1 : 32'h0000_0000;
    if (clear) begin
      {cpu_edges, sys_edges, slow_edges, tbc_edges} <= '0;
    end else begin
      cpu_edges <= cpu_edges + (cpu_clock & ~last_reg[3]);
      sys_edges <= sys_edges + (system_clock & ~last_reg[2]);
      slow_edges <= slow_edges + (slow_clock & ~last_reg[1]);
      tbc_edges <= tbc_edges + (timebase_clock & ~last_reg[0]);
    end
    if (system_clock && !last_reg[2]) begin
      sys_period <= since_reg + 1;
      since_reg <= 32'h0000_0000;
    end
    if (!system_clock && last_reg[2] && high_reg < sys_min_high) begin
      sys_min_high <= high_reg;
    end
  end
endmodule : scmc_clock_sink

`default_nettype wire

/* testbench/system_clock_mode_control_tb_top.sv */
// Purpose: Self-checking bench of the clock and mode control.
// Assumes: Slow oscillator half period shortened to 20 reference cycles.
// Notes: Expected modes and periods come from a small behavioural model.
`timescale 1ns/1ns
`default_nettype none

module system_clock_mode_control_tb_top;
  localparam int FH = 6;
  localparam int SH = 20;
  logic clk, rst, speed, idle_sel, keep, wdt, halt, wake, clear;
  logic [2:0] div;
  logic cpu_clk, sys_clk, slow_clk, tbc_clk, fast_on, slow_on, switching;
  logic [2:0] mode;
  logic [31:0] cpu_e, sys_e, slow_e, tbc_e, period, min_high;
  int error_cnt = 0;
  int checks_done = 0;
  integer seed = 32'h7d14_9031;

  scmc_top #(.FAST_HALF(FH), .SLOW_HALF(SH)) u_scmc_top (
    .clk(clk), .rst(rst), .clock_speed_select(speed), .clock_divider_select(div),
    .idle_select(idle_sel), .idle_clock_keep(keep), .wdt_enable(wdt), .halt_req(halt),
    .wake_req(wake), .cpu_clock(cpu_clk), .system_clock(sys_clk), .slow_clock(slow_clk),
    .timebase_clock(tbc_clk), .fast_rc_osc_on(fast_on), .slow_rc_osc_on(slow_on),
    .op_mode(mode), .clock_switching(switching));

  scmc_clock_sink u_scmc_clock_sink (
    .clk(clk), .clear(clear), .cpu_clock(cpu_clk), .system_clock(sys_clk),
    .slow_clock(slow_clk), .timebase_clock(tbc_clk), .cpu_edges(cpu_e),
    .sys_edges(sys_e), .slow_edges(slow_e), .tbc_edges(tbc_e), .sys_period(period),
    .sys_min_high(min_high));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Model and checks
  // ----------------------------------------------------------------------
  function automatic int halt_mode(input bit i, input bit k, input bit w);
    return i ? (k ? 3 : 2) : (w ? 5 : 4);
  endfunction : halt_mode

  function automatic int run_mode();
    return (speed || div >= 3'h2) ? 0 : 1;
  endfunction : run_mode

  function automatic int exp_period();
    if (speed) return 2 * FH;
    if (div < 3'h2) return 2 * SH;
    return (2 * FH) << (8 - div);
  endfunction : exp_period

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic pulse(input bit is_halt);
    @(posedge clk);
    halt <= is_halt;
    wake <= !is_halt;
    @(posedge clk);
    halt <= 1'b0;
    wake <= 1'b0;
    cyc(3);
  endtask : pulse

  // Mask order is core, system, slow, time-base; a set bit means running.
  task automatic expect_mask(input logic [3:0] m);
    cyc(120);
    @(posedge clk);
    clear <= 1'b1;
    @(posedge clk);
    clear <= 1'b0;
    cyc(200);
    check("mask", {28'h0, m}, {28'h0, cpu_e != 0, sys_e != 0, slow_e != 0, tbc_e != 0});
  endtask : expect_mask

  task automatic halt_cycle(input bit i, input bit k, input bit w, input logic [3:0] m);
    int rm;
    rm = run_mode();
    @(posedge clk);
    idle_sel <= i;
    keep <= k;
    wdt <= w;
    pulse(1'b1);
    check("op_mode halt", halt_mode(i, k, w), {29'h0, mode});
    check("osc halt", {30'h0, i && k && rm == 0, i || w}, {30'h0, fast_on, slow_on});
    expect_mask(m);
    pulse(1'b1);
    check("op_mode halt again", halt_mode(i, k, w), {29'h0, mode});
    pulse(1'b0);
    check("op_mode wake", rm, {29'h0, mode});
  endtask : halt_cycle

  task automatic select(input bit s, input logic [2:0] d);
    int p;
    int q;
    q = exp_period();
    @(posedge clk);
    speed <= s;
    div <= d;
    cyc(2);
    p = exp_period();
    // The old source must reach a low phase before the switch can happen.
    cyc(4 * p + q + 100);
    check("period", p, period);
    check("switching", 0, {31'h0, switching});
    check("op_mode run", run_mode(), {29'h0, mode});
  endtask : select

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    speed = 1'b1;
    div = 3'h0;
    {idle_sel, keep, wdt, halt, wake, clear} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(60);
    check("op_mode reset", 0, {29'h0, mode});
    check("osc on", 2'b11, {fast_on, slow_on});
    expect_mask(4'hF);
    pulse(1'b0);
    check("op_mode wake ignored", 0, {29'h0, mode});
    halt_cycle(1'b1, 1'b0, 1'b0, 4'h3);
    halt_cycle(1'b1, 1'b1, 1'b0, 4'h7);
    halt_cycle(1'b0, 1'b0, 1'b1, 4'h2);
    halt_cycle(1'b0, 1'b0, 1'b0, 4'h0);
    for (int c = 0; c < 8; c++) begin
      select(1'b0, c[2:0]);
    end
    repeat (4) begin
      select($random(seed) & 1, $random(seed) & 7);
    end
    select(1'b0, 3'h0);
    expect_mask(4'hF);
    check("fast off slow", 0, {31'h0, fast_on});
    halt_cycle(1'b1, 1'b1, 1'b0, 4'h7);
    select(1'b1, 3'h0);
    check("min high", 1, {31'h0, min_high >= FH});
    complete_run();
  end

  initial begin
    #900_000;
    error_cnt++;
    complete_run();
  end
endmodule : system_clock_mode_control_tb_top

`default_nettype wire
